// File: logic/isr_pkg.sv
/*
 * Constants and types shared by the interrupt status and result register block.
 * Assumes byte-wide registers reached through a simple synchronous byte port.
 */
package isr_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ISR_OFF_EVENT_FLAGS = 8'h21;
	localparam logic [7:0] ISR_OFF_VIS_LOW = 8'h22;
	localparam logic [7:0] ISR_OFF_VIS_HIGH = 8'h23;
	localparam logic [7:0] ISR_OFF_IR_LOW = 8'h24;
	localparam logic [7:0] ISR_OFF_IR_HIGH = 8'h25;
	localparam logic [7:0] ISR_OFF_P1_LOW = 8'h26;
	localparam logic [7:0] ISR_OFF_P1_HIGH = 8'h27;
	localparam logic [7:0] ISR_OFF_P2_LOW = 8'h28;

	// ------------------------------------------------------------
	// status field layout
	// ------------------------------------------------------------
	localparam int ISR_FLAG_W = 6;
	localparam int ISR_BIT_CMD = 5;
	localparam int ISR_BIT_P3 = 4;
	localparam int ISR_BIT_P2 = 3;
	localparam int ISR_BIT_P1 = 2;
	localparam int ISR_BIT_AMB_HI = 1;
	localparam int ISR_BIT_AMB_LO = 0;

	// ------------------------------------------------------------
	// reset values and encodings
	// ------------------------------------------------------------
	localparam logic [ISR_FLAG_W-1:0] ISR_FLAGS_RESET = 6'h00;
	localparam logic [15:0] ISR_RESULT_RESET = 16'h0000;
	localparam logic [7:0] ISR_BYTE_ZERO = 8'h00;
	localparam logic [1:0] ISR_RESERVED_ZERO = 2'h0;
	localparam logic [1:0] ISR_ALERT_KEEP = 2'h3;
	localparam logic ISR_MODE_HOST_CLEAR = 1'b0;

	typedef enum logic [2:0] {
		ISR_CH_VIS,
		ISR_CH_IR,
		ISR_CH_P1,
		ISR_CH_P2,
		ISR_CH_P3
	} isr_channel_t;

endpackage

// File: logic/isr_flag_if.sv
/*
 * Carrier between the register front end and the status flag keeper.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface isr_flag_if;
	import isr_pkg::*;
	logic [ISR_FLAG_W-1:0] set;
	logic [ISR_FLAG_W-1:0] host_clear;
	logic auto_clear;
	logic [ISR_FLAG_W-1:0] keep;
	logic [ISR_FLAG_W-1:0] flags;

	modport front (output set, output host_clear, output auto_clear, output keep,
		input flags);
	modport keeper (input set, input host_clear, input auto_clear, input keep,
		output flags);
endinterface

// File: logic/isr_flags.sv
/*
 * Status flag keeper: sticky event flags with host and sequencer clearing.
 * Assumes the front end has already decoded writes and mode settings.
 */
`timescale 1ns/100ps
module isr_flags (
	// clock and control
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// flag traffic
	isr_flag_if.keeper fl
);
	import isr_pkg::*;

	typedef struct packed {
		logic [ISR_FLAG_W-1:0] flags;
	} isr_flags_state_t;

	isr_flags_state_t st;
	isr_flags_state_t next_st;

	// ------------------------------------------------------------
	// flag update
	// ------------------------------------------------------------
	always_comb begin
		logic [ISR_FLAG_W-1:0] clr;
		clr = fl.host_clear;
		if (fl.auto_clear) begin
			clr = clr | ~fl.keep;
		end
		next_st = st;
		// set wins over a clear in the same cycle
		next_st.flags = (st.flags & ~clr) | fl.set;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			st.flags <= ISR_FLAGS_RESET;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign fl.flags = st.flags;

endmodule // isr_flags

// File: logic/isr_regs.sv
/*
 * Interrupt status and measurement result registers with the interrupt pin.
 * Assumes the serial port logic presents decoded byte reads and writes, and
 * the sequencer presents finished measurements and event strobes.
 */
`timescale 1ns/100ps

module isr_regs (
	// clock and control
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// configuration
	input wire logic int_mode,
	input wire logic [isr_pkg::ISR_FLAG_W-1:0] irq_enable,
	input wire logic [5:0] proximity_alert_mode,
	input wire logic [15:0] proximity_three_threshold,
	// sequencer
	input wire logic meas_valid,
	input wire isr_pkg::isr_channel_t meas_channel,
	input wire logic [15:0] meas_value,
	input wire logic [1:0] ambient_event,
	input wire logic command_done,
	input wire logic sequencer_clear,
	// interrupt pin
	output logic int_request
);
	import isr_pkg::*;

	typedef struct packed {
		logic [15:0] ambient_visible_result;
		logic [15:0] ambient_infrared_result;
		logic [15:0] proximity_one_result;
		logic [15:0] proximity_two_result;
		logic [ISR_FLAG_W-1:0] pending;
		logic [7:0] rdata;
	} isr_regs_state_t;

	isr_regs_state_t st;
	isr_regs_state_t next_st;
	isr_flag_if fl ();

	// ------------------------------------------------------------
	// flag keeper
	// ------------------------------------------------------------
	isr_flags u_flags (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.fl(fl)
	);

	logic flag_write;
	logic [7:0] status_byte;

	assign flag_write = reg_write && (reg_addr == ISR_OFF_EVENT_FLAGS);
	assign status_byte = {ISR_RESERVED_ZERO, fl.flags};

	// ------------------------------------------------------------
	// flag control
	// ------------------------------------------------------------
	always_comb begin
		fl.host_clear = flag_write ? reg_wdata[ISR_FLAG_W-1:0] : ISR_FLAGS_RESET;
		fl.auto_clear = sequencer_clear && (int_mode != ISR_MODE_HOST_CLEAR);
		fl.keep = ISR_FLAGS_RESET;
		fl.keep[ISR_BIT_P1] = proximity_alert_mode[1:0] == ISR_ALERT_KEEP;
		fl.keep[ISR_BIT_P2] = proximity_alert_mode[3:2] == ISR_ALERT_KEEP;
		fl.keep[ISR_BIT_P3] = proximity_alert_mode[5:4] == ISR_ALERT_KEEP;
		// flags rise from the pending copy, a cycle after the result bytes land
		fl.set = st.pending;
	end

	// ------------------------------------------------------------
	// results, pending events and read data
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.pending = ISR_FLAGS_RESET;
		next_st.pending[ISR_BIT_CMD] = command_done;
		next_st.pending[ISR_BIT_AMB_HI:ISR_BIT_AMB_LO] = ambient_event;

		// host writes to result bytes are allowed; a measurement in the same cycle wins
		if (reg_write) begin
			unique case (reg_addr)
				ISR_OFF_VIS_LOW: next_st.ambient_visible_result[7:0] = reg_wdata;
				ISR_OFF_VIS_HIGH: next_st.ambient_visible_result[15:8] = reg_wdata;
				ISR_OFF_IR_LOW: next_st.ambient_infrared_result[7:0] = reg_wdata;
				ISR_OFF_IR_HIGH: next_st.ambient_infrared_result[15:8] = reg_wdata;
				ISR_OFF_P1_LOW: next_st.proximity_one_result[7:0] = reg_wdata;
				ISR_OFF_P1_HIGH: next_st.proximity_one_result[15:8] = reg_wdata;
				ISR_OFF_P2_LOW: next_st.proximity_two_result[7:0] = reg_wdata;
				default: ;
			endcase
		end

		if (meas_valid) begin
			unique case (meas_channel)
				ISR_CH_VIS: next_st.ambient_visible_result = meas_value;
				ISR_CH_IR: next_st.ambient_infrared_result = meas_value;
				ISR_CH_P1: begin
					next_st.proximity_one_result = meas_value;
					next_st.pending[ISR_BIT_P1] = 1'b1;
				end
				ISR_CH_P2: begin
					next_st.proximity_two_result = meas_value;
					next_st.pending[ISR_BIT_P2] = 1'b1;
				end
				ISR_CH_P3: begin
					// no result bytes mapped here; only the threshold test matters
					next_st.pending[ISR_BIT_P3] = meas_value > proximity_three_threshold;
				end
				default: ;
			endcase
		end

		if (reg_read) begin
			unique case (reg_addr)
				ISR_OFF_EVENT_FLAGS: next_st.rdata = status_byte;
				ISR_OFF_VIS_LOW: next_st.rdata = st.ambient_visible_result[7:0];
				ISR_OFF_VIS_HIGH: next_st.rdata = st.ambient_visible_result[15:8];
				ISR_OFF_IR_LOW: next_st.rdata = st.ambient_infrared_result[7:0];
				ISR_OFF_IR_HIGH: next_st.rdata = st.ambient_infrared_result[15:8];
				ISR_OFF_P1_LOW: next_st.rdata = st.proximity_one_result[7:0];
				ISR_OFF_P1_HIGH: next_st.rdata = st.proximity_one_result[15:8];
				ISR_OFF_P2_LOW: next_st.rdata = st.proximity_two_result[7:0];
				default: next_st.rdata = ISR_BYTE_ZERO;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			st.ambient_visible_result <= ISR_RESULT_RESET;
			st.ambient_infrared_result <= ISR_RESULT_RESET;
			st.proximity_one_result <= ISR_RESULT_RESET;
			st.proximity_two_result <= ISR_RESULT_RESET;
			st.pending <= ISR_FLAGS_RESET;
			st.rdata <= ISR_BYTE_ZERO;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign reg_rdata = st.rdata;
	assign int_request = |(fl.flags & irq_enable);

endmodule // isr_regs

// File: sim/isr_host_model.sv
/* Host model: byte register reads and writes.
 Assumes requests are taken on the rising clk. */
`timescale 1ns/100ps
module isr_host_model (
	// byte port
	input wire logic clk,
	input wire logic [7:0] reg_rdata,
	output logic [7:0] reg_addr,
	output logic reg_write,
	output logic reg_read,
	output logic [7:0] reg_wdata
);
	initial begin
		reg_addr = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_wdata = 8'h00;
	end
	// flags cleared by write-one in either int_mode setting
	task automatic wr(input logic [7:0] a, d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		@(posedge clk);
		d = reg_rdata;
	endtask
endmodule // isr_host_model

// File: sim/isr_regs_asserts.sv
/* Checker for the status and result register block.
 Sees only the top ports; bound after the module. */
`timescale 1ns/100ps
module isr_regs_asserts (
	// watched ports
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic int_mode,
	input wire logic [isr_pkg::ISR_FLAG_W-1:0] irq_enable,
	input wire logic [5:0] proximity_alert_mode,
	input wire logic [15:0] proximity_three_threshold,
	input wire logic meas_valid,
	input wire isr_pkg::isr_channel_t meas_channel,
	input wire logic [15:0] meas_value,
	input wire logic [1:0] ambient_event,
	input wire logic command_done,
	input wire logic sequencer_clear,
	input wire logic int_request
);
	import isr_pkg::*;
	logic quiet;
	// no event arrives in this cycle, so none can set a flag in the next one
	assign quiet = ce && !meas_valid && !command_done && ambient_event == 2'h0;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_reset_zero: assert property (disable iff (1'b0) !resetn |=>
		reg_rdata == 8'h00 && !int_request) else $error("not zero after reset");
	a_status_reserved: assert property (ce && reg_read && reg_addr == 8'h21 |=>
		reg_rdata[7:6] == 2'h0) else $error("reserved status bits set");
	a_pin_gated: assert property (irq_enable == '0 |-> !int_request)
		else $error("pin high with no enable");
	a_cmd_raise: assert property (ce && command_done && irq_enable[5] |->
		##[1:2] int_request) else $error("command flag did not raise pin");
	a_w1c_clear: assert property (quiet ##1 (quiet && reg_write && reg_addr == 8'h21
		&& reg_wdata[5:0] == 6'h3F) |=> !int_request) else $error("write-one kept pin");
	a_auto_clear: assert property (quiet ##1 (quiet && int_mode && sequencer_clear
		&& proximity_alert_mode == 6'h00) |=> !int_request) else $error("auto clear missed");
	a_p3_raise: assert property (ce && meas_valid && meas_channel == ISR_CH_P3
		&& meas_value > proximity_three_threshold && irq_enable[4] |=> ##1 int_request)
		else $error("proximity three flag missing");
	a_vis_rw: assert property (ce && reg_write && reg_addr == 8'h22 && !meas_valid ##1
		(ce && reg_read && reg_addr == 8'h22 && !reg_write) |=> reg_rdata == $past(reg_wdata, 2))
		else $error("visible low byte lost write");
	c_p3: cover property (meas_valid && meas_channel == ISR_CH_P3);
	c_auto: cover property (int_mode && sequencer_clear);
	c_w1c: cover property (reg_write && reg_addr == 8'h21);
endmodule // isr_regs_asserts
bind isr_regs isr_regs_asserts u_chk (.clk, .resetn, .ce, .reg_addr, .reg_write, .reg_read,
	.reg_wdata, .reg_rdata, .int_mode, .irq_enable, .proximity_alert_mode,
	.proximity_three_threshold, .meas_valid, .meas_channel, .meas_value, .ambient_event,
	.command_done, .sequencer_clear, .int_request);

// File: sim/tb_isr_regs.sv
/* Bench for the status and result register block.
 Assumes the host model drives the byte port. */
`timescale 1ns/100ps
module tb_isr_regs;
	import isr_pkg::*;
	logic clk = 1'b0, resetn = 1'b0, ce = 1'b1, int_mode = 1'b0, meas_valid = 1'b0;
	logic command_done = 1'b0, sequencer_clear = 1'b0, reg_write, reg_read, int_request;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [5:0] irq_enable = 6'h00, proximity_alert_mode = 6'h00;
	logic [15:0] proximity_three_threshold = 16'h0100, meas_value = 16'h0000;
	logic [1:0] ambient_event = 2'h0;
	isr_channel_t meas_channel = ISR_CH_VIS;
	logic [7:0] exp_b [7] = '{8'h34, 8'h12, 8'h5A, 8'hA5, 8'hEF, 8'hBE, 8'hC3};
	int fails = 0, compares = 0;
	always #50 clk = ~clk;
	isr_regs u_dut (.clk, .resetn, .ce, .reg_addr, .reg_write, .reg_read, .reg_wdata,
		.reg_rdata, .int_mode, .irq_enable, .proximity_alert_mode,
		.proximity_three_threshold, .meas_valid, .meas_channel, .meas_value,
		.ambient_event, .command_done, .sequencer_clear, .int_request);
	isr_host_model u_host (.clk, .reg_rdata, .reg_addr, .reg_write, .reg_read, .reg_wdata);
	task automatic cmp(input logic [7:0] g, e);
		compares++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk(input logic [7:0] a, e);
		logic [7:0] d;
		u_host.rd(a, d);
		cmp(d, e);
	endtask
	// sample the pin once the edge has landed
	task automatic pin(input logic e);
		#1;
		cmp(8'(int_request), 8'(e));
		@(posedge clk);
	endtask
	task automatic meas(input isr_channel_t c, input logic [15:0] v);
		meas_channel <= c;
		meas_value <= v;
		meas_valid <= 1'b1;
		@(posedge clk);
		meas_valid <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic clr;
		sequencer_clear <= 1'b1;
		@(posedge clk);
		sequencer_clear <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic test_done;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		#1000000;
		fails++;
		test_done();
	end
	initial begin
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		for (int a = 8'h21; a <= 8'h29; a++) begin
			chk(8'(a), 8'h00);
		end
		$display("test reset done");
		irq_enable <= 6'h3F;
		meas(ISR_CH_VIS, 16'h1234);
		meas(ISR_CH_IR, 16'hA55A);
		meas(ISR_CH_P1, 16'hBEEF);
		meas(ISR_CH_P2, 16'h77C3);
		pin(1'b1);
		foreach (exp_b[i]) begin
			chk(8'h22 + 8'(i), exp_b[i]);
		end
		u_host.wr(8'h22, 8'h5E);
		chk(8'h22, 8'h5E);
		chk(8'h21, 8'h0C);
		ambient_event <= 2'h2;
		command_done <= 1'b1;
		@(posedge clk);
		ambient_event <= 2'h0;
		command_done <= 1'b0;
		repeat (2) @(posedge clk);
		chk(8'h21, 8'h2E);
		u_host.wr(8'h21, 8'hC4);
		chk(8'h21, 8'h2A);
		irq_enable <= 6'h04;
		pin(1'b0);
		irq_enable <= 6'h08;
		pin(1'b1);
		u_host.wr(8'h21, 8'h3F);
		chk(8'h21, 8'h00);
		$display("test results done");
		int_mode <= 1'b1;
		proximity_alert_mode <= 6'h0C;
		meas(ISR_CH_P1, 16'h0001);
		meas(ISR_CH_P2, 16'h0002);
		clr();
		chk(8'h21, 8'h08);
		proximity_alert_mode <= 6'h00;
		clr();
		chk(8'h21, 8'h00);
		int_mode <= 1'b0;
		$display("test auto clear done");
		irq_enable <= 6'h10;
		meas(ISR_CH_P3, 16'h0100);
		chk(8'h21, 8'h00);
		meas(ISR_CH_P3, 16'h0101);
		chk(8'h21, 8'h10);
		resetn <= 1'b0;
		@(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		chk(8'h21, 8'h00);
		chk(8'h26, 8'h00);
		$display("test threshold done");
		// clock enable low: nothing may be taken or change
		ce <= 1'b0;
		meas(ISR_CH_P1, 16'h5555);
		u_host.wr(8'h27, 8'h66);
		ce <= 1'b1;
		@(posedge clk);
		chk(8'h26, 8'h00);
		chk(8'h27, 8'h00);
		chk(8'h21, 8'h00);
		$display("test clock enable done");
		test_done();
	end
endmodule // tb_isr_regs
